// ===== design/ilu_top.sv
// interrupt latch and enable unit: latches, enables, priority pick and cpu hand-off
// assumes requests and cpu strobes come from logic on sys_clk_in, one-cycle pulses
`timescale 1ns/10ps
`include "ilu_map.svh"
module ilu_top (
  // clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            rst_b_in,
  // apb slave
  input  wire logic            psel_in,
  input  wire logic            penable_in,
  input  wire logic            pwrite_in,
  input  wire logic [11:0]     paddr_in,
  input  wire logic [31:0]     pwdata_in,
  output logic      [31:0]     prdata_out,
  output logic                 pready_out,
  output logic                 pslverr_out,
  // interrupt sources
  input  wire logic [15:2]     src_req_in,
  input  wire ilu_pkg::ilu_sel_t alt_req_in,
  // cpu core
  input  wire logic            cpu_ack_in,
  input  wire ilu_pkg::ilu_id_t cpu_ack_id_in,
  input  wire logic            cpu_ret_in,
  input  wire logic            cpu_ret_imf_in,
  input  wire logic            cpu_ei_in,
  input  wire logic            cpu_di_in,
  output logic                 cpu_irq_out,
  output ilu_pkg::ilu_id_t     cpu_vec_out,
  output logic                 imf_push_out
);
  import ilu_pkg::*;

  ilu_reg_if rif ();

  ilu_word_t   lat_r;
  ilu_word_t   lat_nxt;
  logic [15:4] ef_r;
  logic [15:4] ef_nxt;
  logic        imf_r;
  logic        imf_nxt;
  logic        push_r;
  logic        push_nxt;
  ilu_sel_t    sel_r;
  ilu_sel_t    sel_nxt;
  logic        irq_r;
  logic        irq_nxt;
  ilu_id_t     vec_r;
  ilu_id_t     vec_nxt;
  ilu_word_t   set_vec;
  ilu_word_t   sw_clr;
  ilu_word_t   ack_clr;
  ilu_word_t   acc_nxt;
  ilu_word_t   pend_nxt;
  ilu_word_t   pend_now;
  ilu_word_t   below_mask;

  ilu_apb u_apb (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .rif         (rif.bus)
  );

  // read views; bits 3..1 of the enable word read zero
  assign rif.en_rd  = {ef_r, 3'b000, imf_r}; // R24
  assign rif.lat_rd = lat_r;                 // R6
  assign rif.sel_rd = sel_r;

  // request gating: shared levels listen only to the selected source
  always_comb begin
    set_vec              = '0;
    set_vec[15:2]        = src_req_in; // R1
    set_vec[`ILU_SH0]    = sel_r[0] ? alt_req_in[0] : src_req_in[`ILU_SH0]; // R22
    set_vec[`ILU_SH1]    = sel_r[1] ? alt_req_in[1] : src_req_in[`ILU_SH1]; // R22
    set_vec[`ILU_SH2]    = sel_r[2] ? alt_req_in[2] : src_req_in[`ILU_SH2]; // R22
  end

  // clear sources; software cannot set, and trap/watchdog bits are
  // trusted to be written as ones, nothing protects them here
  always_comb begin
    sw_clr  = rif.wr_lat_stb ? (~rif.wdata & `ILU_LAT_MASK) : '0; // R4 R5 R7
    ack_clr = cpu_ack_in ? ((16'h0001 << cpu_ack_id_in) & `ILU_LAT_MASK) : '0; // R2
  end

  // per-latch next value; set beats either clear in the same cycle
  genvar gi;
  generate
    for (gi = `ILU_LAT_LO; gi <= `ILU_LAT_HI; gi++) begin : g_lat
      assign lat_nxt[gi] = set_vec[gi] | (lat_r[gi] & ~sw_clr[gi] & ~ack_clr[gi]); // R23 R1 R2
    end
  endgenerate
  assign lat_nxt[1:0] = 2'b00;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lat_r <= `ILU_LAT_RST; // R3
    end else begin
      lat_r <= lat_nxt;
    end
  end

  // enable flags, selector and master enable; later lines win:
  // bus write, then di/ei, then return, then acceptance
  always_comb begin
    ef_nxt   = ef_r;
    sel_nxt  = sel_r;
    imf_nxt  = imf_r;
    push_nxt = push_r;
    if (rif.wr_en_stb) begin
      ef_nxt  = rif.wdata[`ILU_EF_HI:`ILU_EF_LO]; // R10 R17
      imf_nxt = rif.wdata[`ILU_IMF_BIT];          // R15
    end
    if (rif.wr_sel_stb)
      sel_nxt = rif.wdata[2:0];
    if (cpu_di_in)
      imf_nxt = 1'b0;           // R16
    else if (cpu_ei_in)
      imf_nxt = 1'b1;           // R16
    if (cpu_ret_in)
      imf_nxt = cpu_ret_imf_in; // R14
    if (cpu_ack_in) begin
      push_nxt = imf_r;         // R13
      imf_nxt  = 1'b0;          // R13
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ef_r   <= `ILU_EF_RST;  // R18
      imf_r  <= `ILU_IMF_RST; // R15
      push_r <= `ILU_IMF_RST;
      sel_r  <= `ILU_SEL_RST;
    end else begin
      ef_r   <= ef_nxt;
      imf_r  <= imf_nxt;
      push_r <= push_nxt;
      sel_r  <= sel_nxt;
    end
  end

  // acceptance looks at next state so irq never lags a clear
  always_comb begin
    acc_nxt  = `ILU_NMI_MASK | ({ef_nxt, 4'h0} & {16{imf_nxt}}); // R9 R11 R12
    pend_nxt = lat_nxt & acc_nxt;
    irq_nxt  = |pend_nxt;
    vec_nxt  = '0;
    // lowest index is highest priority; trap before watchdog, arbitrary
    for (int k = `ILU_LAT_HI; k >= `ILU_LAT_LO; k--) begin
      if (pend_nxt[k])
        vec_nxt = ilu_id_t'(k); // R21
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_r <= 1'b0;
      vec_r <= '0;
    end else begin
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
    end
  end

  assign cpu_irq_out  = irq_r;
  assign cpu_vec_out  = vec_r;
  assign imf_push_out = push_r;

  // helpers read only by the checks below
  assign pend_now   = lat_r & (`ILU_NMI_MASK | ({ef_r, 4'h0} & {16{imf_r}}));
  assign below_mask = (16'h0001 << cpu_vec_out) - 16'h0001;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_set_sticks: assert property (|set_vec |=> (lat_r & $past(set_vec)) == $past(set_vec)) // R1
    else $error("requested latch not set");
  a_ack_clears: assert property (cpu_ack_in && cpu_ack_id_in >= 4'h2 && !set_vec[cpu_ack_id_in]
                                 |=> !lat_r[$past(cpu_ack_id_in)]) // R2
    else $error("accepted latch not cleared");
  a_sw_clear: assert property (rif.wr_lat_stb
                               |=> (lat_r & $past(~rif.wdata & `ILU_LAT_MASK & ~set_vec)) == 16'h0000) // R4
    else $error("software clear missed");
  a_sw_no_set: assert property (##1 ((lat_r & ~$past(lat_r) & ~$past(set_vec)) == 16'h0000)) // R5
    else $error("latch rose without request");
  a_nmi_pass: assert property ((lat_r & `ILU_NMI_MASK) != 16'h0000 |-> cpu_irq_out && cpu_vec_out <= 4'h3) // R9
    else $error("non-maskable request not presented");
  a_imf_blocks: assert property (!imf_r |-> !(cpu_irq_out && cpu_vec_out >= 4'h4)) // R11
    else $error("maskable request passed with master off");
  a_ef_gates: assert property (cpu_irq_out && cpu_vec_out >= 4'h4 |-> ef_r[cpu_vec_out]) // R12
    else $error("disabled source presented");
  a_ack_pushes: assert property (cpu_ack_in |=> !imf_r && imf_push_out == $past(imf_r)) // R13
    else $error("master enable not stacked and cleared");
  a_ret_restore: assert property (cpu_ret_in && !cpu_ack_in |=> imf_r == $past(cpu_ret_imf_in)) // R14
    else $error("return did not restore master enable");
  a_ei_di: assert property (cpu_ei_in && !cpu_di_in && !cpu_ret_in && !cpu_ack_in ##1 !cpu_ack_in[*2]
                            |-> imf_r || $past(cpu_ret_in)) // R16
    else $error("enable instruction lost");
  a_prio_pick: assert property (cpu_irq_out |-> (pend_now & below_mask) == 16'h0000 && pend_now[cpu_vec_out]) // R21
    else $error("lower priority request chosen");
  a_sel_ignore: assert property (!sel_r[0] && !src_req_in[`ILU_SH0] && !lat_r[`ILU_SH0] |=> !lat_r[`ILU_SH0]) // R22
    else $error("unselected source latched");
  a_set_wins: assert property (rif.wr_lat_stb && set_vec[`ILU_LAT_HI] |=> lat_r[`ILU_LAT_HI]) // R23
    else $error("set lost to clear");

  c_mask_accept: cover property (cpu_irq_out && cpu_vec_out >= 4'h4 ##1 cpu_ack_in);
  c_nmi_accept:  cover property (cpu_irq_out && cpu_vec_out == 4'h2 ##1 cpu_ack_in);
  c_ret_nested:  cover property (cpu_ack_in ##[1:20] cpu_ret_in && cpu_ret_imf_in);
  c_clear_race:  cover property (rif.wr_lat_stb && (set_vec & ~rif.wdata) != 16'h0000);
endmodule

// ===== shared/ilu_map.svh
// interrupt latch and enable unit: register indices, field positions, resets
// assumes a 16-bit register view placed in the low half of 32-bit apb words
//
// Operation
// R1: one request latch per source except software and undefined; request sets it
// R2: accepting an interrupt clears that source's latch
// R3: reset clears every request latch
// R4: latches sit at 003CH/003DH; writing zero to a bit clears it
// R5: writing one to a latch bit does nothing; only hardware sets latches
// R6: reading the latch register returns every pending request
// R7: software never clears address trap or watchdog latches; writes ones there
// R8: software clears latches with plain loads, never read-modify-write
// R9: non-maskable requests pass whatever the enable register holds
// R10: enable register at 003AH/003BH, plain and read-modify-write access
// R11: master enable low blocks every maskable request
// R12: with master enable set, a source also needs its own enable
// R13: on acceptance push the master enable value, then clear it
// R14: either return instruction reloads master enable from the stacked value
// R15: master enable is bit 0 of the low enable byte, resets to zero
// R16: enable instruction sets master enable, disable instruction clears it
// R17: enable bits 15 to 4 each gate one maskable source
// R18: reset clears all source enables
// R19: software drops master enable around enable or latch edits
// R20: software never sets master and source enables in one write
// R21: several pending: highest fixed priority wins; non-maskables unordered
// R22: a shared level latches only the source chosen by the selector
// R23: hardware set beats a same-cycle software clear
// R24: enable bits 3 to 1 ignore writes and read as don't care
`ifndef ILU_MAP_SVH
`define ILU_MAP_SVH

// register indices; byte address is four times the index
`define ILU_IDX_EN    8'h3A
`define ILU_IDX_LAT   8'h3C
`define ILU_IDX_SEL   8'h3E

// reset values
`define ILU_LAT_RST   16'h0000
`define ILU_EF_RST    12'h000
`define ILU_IMF_RST   1'b0
`define ILU_SEL_RST   3'h0
`define ILU_RD_RST    32'h0000_0000

// field positions
`define ILU_IMF_BIT   0
`define ILU_EF_LO     4
`define ILU_EF_HI     15
`define ILU_LAT_LO    2
`define ILU_LAT_HI    15
`define ILU_NMI_MASK  16'h000C
`define ILU_LAT_MASK  16'hFFFC

// shared priority levels and their selector bits
`define ILU_SH0       9
`define ILU_SH1       14
`define ILU_SH2       15

`endif

// ===== shared/ilu_pkg.sv
// interrupt latch and enable unit: shared types
// assumes ilu_map.svh holds every number
package ilu_pkg;
  typedef logic [15:0] ilu_word_t;
  typedef logic [3:0]  ilu_id_t;
  typedef logic [2:0]  ilu_sel_t;
endpackage

// ===== shared/ilu_reg_if.sv
// interrupt latch and enable unit: strobes and read values between bus slave and core
// assumes one clock domain; strobes are one-cycle pulses
`timescale 1ns/10ps
interface ilu_reg_if;
  import ilu_pkg::*;
  logic      wr_en_stb;
  logic      wr_lat_stb;
  logic      wr_sel_stb;
  ilu_word_t wdata;
  ilu_word_t en_rd;
  ilu_word_t lat_rd;
  ilu_sel_t  sel_rd;
  modport bus  (output wr_en_stb, wr_lat_stb, wr_sel_stb, wdata, input en_rd, lat_rd, sel_rd);
  modport core (input wr_en_stb, wr_lat_stb, wr_sel_stb, wdata, output en_rd, lat_rd, sel_rd);
endinterface

// ===== design/ilu_apb.sv
// interrupt latch and enable unit: apb slave front end
// assumes a zero-wait apb master on sys_clk_in; registers live in the core
`timescale 1ns/10ps
`include "ilu_map.svh"
module ilu_apb (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // register strobes
  ilu_reg_if.bus           rif
);
  import ilu_pkg::*;

  logic        hit_en;
  logic        hit_lat;
  logic        hit_sel;
  logic        acc;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // address decode, index times four
  always_comb begin
    hit_en  = (paddr_in == {2'b00, `ILU_IDX_EN, 2'b00});
    hit_lat = (paddr_in == {2'b00, `ILU_IDX_LAT, 2'b00});
    hit_sel = (paddr_in == {2'b00, `ILU_IDX_SEL, 2'b00});
    acc     = psel_in & penable_in;
  end

  // writes land at the access edge; never a wait state
  assign pready_out      = 1'b1;
  assign pslverr_out     = acc & ~(hit_en | hit_lat | hit_sel);
  assign rif.wr_en_stb   = acc & pwrite_in & hit_en;  // R10
  assign rif.wr_lat_stb  = acc & pwrite_in & hit_lat; // R4
  assign rif.wr_sel_stb  = acc & pwrite_in & hit_sel;
  assign rif.wdata       = pwdata_in[15:0];
  assign prdata_out      = prdata_r;

  // read data caught at the setup edge so it comes from a flop
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel_in && !penable_in && !pwrite_in) begin
      prdata_nxt = `ILU_RD_RST;
      if (hit_en)
        prdata_nxt = {16'h0000, rif.en_rd};       // R10
      else if (hit_lat)
        prdata_nxt = {16'h0000, rif.lat_rd};      // R6
      else if (hit_sel)
        prdata_nxt = {29'h0000_0000, rif.sel_rd};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_r <= `ILU_RD_RST;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_apb_unmapped: assert property (acc && !(hit_en || hit_lat || hit_sel) |-> pslverr_out && !rif.wr_en_stb)
    else $error("unmapped access not flagged");
  a_apb_lat_read: assert property (psel_in && !penable_in && !pwrite_in && hit_lat |=> prdata_out == {16'h0000, $past(rif.lat_rd)}) // R6
    else $error("latch read returns wrong value");
endmodule

// ===== bench/ilu_cpu_model.sv
// cpu core stand-in: accepts interrupts, returns, runs enable/disable
// assumes the unit's outputs are on clk_in; the bench calls its tasks
`timescale 1ns/10ps
module ilu_cpu_model
  import ilu_pkg::*;
(
  // clock
  input  wire logic    clk_in,
  // from the unit
  input  wire logic    irq_in,
  input  wire ilu_id_t vec_in,
  input  wire logic    push_in,
  // to the unit
  output logic         ack_out,
  output ilu_id_t      id_out,
  output logic         ret_out,
  output logic         ret_imf_out,
  output logic         ei_out,
  output logic         di_out
);
  logic stack [$];

  // idle strobes; id and popped value hold junk outside pulses
  initial begin
    {ack_out, ret_out, ei_out, di_out} = 4'h0;
    id_out = 4'hA;
    ret_imf_out = 1'b1;
  end

  // accept after dly cycles, then stack the pushed master enable
  task automatic accept(input int dly);
    @(posedge clk_in);
    repeat (dly) @(posedge clk_in);
    // ack follows the request line itself, so no strobe is a bare constant
    ack_out <= (irq_in === 1'b1);
    id_out <= vec_in;
    @(posedge clk_in);
    ack_out <= 1'b0;
    id_out <= ~id_out; // stale id never left on the lines
    @(posedge clk_in);
    stack.push_back(push_in);
  endtask

  // return instruction: pop the stacked master enable
  task automatic ret();
    @(posedge clk_in);
    ret_out <= 1'b1;
    ret_imf_out <= stack.pop_back();
    @(posedge clk_in);
    ret_out <= 1'b0;
    ret_imf_out <= ~ret_imf_out;
  endtask

  // enable (1) or disable (0) instruction
  task automatic instr(input logic en);
    @(posedge clk_in);
    ei_out <= en;
    di_out <= ~en;
    @(posedge clk_in);
    {ei_out, di_out} <= 2'b00;
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the interrupt latch and enable unit
// assumes ilu_top with apb registers and the cpu stand-in beside it
`timescale 1ns/10ps
`include "ilu_map.svh"
module tb_top;
  import ilu_pkg::*;
  localparam logic [11:0] A_EN  = 12'({`ILU_IDX_EN, 2'b00});
  localparam logic [11:0] A_LAT = 12'({`ILU_IDX_LAT, 2'b00});
  localparam logic [11:0] A_SEL = 12'({`ILU_IDX_SEL, 2'b00});
  localparam logic [11:0] A_UNM = 12'h100;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:2] src;
  ilu_sel_t    alt;
  logic        ack, ret, ret_imf, ei, di, irq, push;
  ilu_id_t     ack_id, vec;
  int          failures, num_checks;

  ilu_top i_dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .src_req_in(src), .alt_req_in(alt),
    .cpu_ack_in(ack), .cpu_ack_id_in(ack_id), .cpu_ret_in(ret), .cpu_ret_imf_in(ret_imf),
    .cpu_ei_in(ei), .cpu_di_in(di), .cpu_irq_out(irq), .cpu_vec_out(vec), .imf_push_out(push));
  ilu_cpu_model i_cpu (.clk_in(sys_clk), .irq_in(irq), .vec_in(vec), .push_in(push),
    .ack_out(ack), .id_out(ack_id), .ret_out(ret), .ret_imf_out(ret_imf), .ei_out(ei), .di_out(di));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cpu side result as {irq, vec}, sampled one edge later
  task automatic chk_cpu(input logic [4:0] exp);
    @(posedge sys_clk);
    chk32({27'h0, irq, vec}, {27'h0, exp});
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    // upper half carries junk; the unit must ignore it
    pwdata <= {~d, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      test_done();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rd;
    apb(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [31:0] rd;
    apb(1'b0, a, 16'h0000, rd);
    chk32(rd & {16'h0000, m}, {16'h0000, e});
  endtask

  // one-cycle request pulse
  task automatic pulse(input logic [15:2] v, input ilu_sel_t a);
    @(posedge sys_clk);
    src <= v;
    alt <= a;
    @(posedge sys_clk);
    src <= '0;
    alt <= '0;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    test_done();
  end

  // main sequence
  initial begin
    {rst_b, psel, penable, pwrite, last_err} = 5'h00;
    {paddr, pwdata, src, alt} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(A_EN, 16'hFFF1, 16'h0000);
    rdc(A_LAT, 16'hFFFF, 16'h0000);
    chk_cpu(5'h00);
    i_cpu.instr(1'b0);
    wr(A_EN, 16'hFFF0);
    pulse(14'h3FFC, 3'h0);
    rdc(A_LAT, 16'hFFFF, 16'hFFF0);
    chk_cpu(5'h00);
    i_cpu.instr(1'b1);
    chk_cpu(5'h14);
    i_cpu.instr(1'b0);
    chk_cpu(5'h00);
    wr(A_EN, 16'h0020);
    i_cpu.instr(1'b1);
    chk_cpu(5'h15);
    i_cpu.accept(3);
    rdc(A_LAT, 16'hFFFF, 16'hFFD0);
    rdc(A_EN, 16'hFFF1, 16'h0020);
    chk32({31'h0, i_cpu.stack[$]}, 32'h1);
    i_cpu.ret();
    rdc(A_EN, 16'hFFF1, 16'h0021);
    i_cpu.instr(1'b0);
    wr(A_EN, 16'h0000);
    pulse(14'h0003, 3'h0);
    chk_cpu(5'h12);
    i_cpu.accept(0);
    chk_cpu(5'h13);
    i_cpu.accept(1);
    chk_cpu(5'h00);
    i_cpu.ret();
    i_cpu.ret();
    wr(A_LAT, 16'hE83F);
    rdc(A_LAT, 16'hFFFF, 16'hE810);
    wr(A_LAT, 16'hFFFF);
    rdc(A_LAT, 16'hFFFF, 16'hE810);
    // request held across the clearing write
    @(posedge sys_clk);
    src <= 14'h0010;
    wr(A_LAT, 16'hFFBF);
    src <= '0;
    rdc(A_LAT, 16'hFFFF, 16'hE850);
    wr(A_LAT, 16'h000C);
    rdc(A_LAT, 16'hFFFF, 16'h0000);
    wr(A_SEL, 16'h0001);
    pulse(14'h0080, 3'h2);
    rdc(A_LAT, 16'hFFFF, 16'h0000);
    pulse(14'h0000, 3'h1);
    rdc(A_LAT, 16'hFFFF, 16'h0200);
    rdc(A_SEL, 16'h0007, 16'h0001);
    wr(A_EN, 16'h000E);
    rdc(A_EN, 16'hFFF1, 16'h0000);
    wr(A_UNM, 16'hFFFF);
    rdc(A_UNM, 16'hFFFF, 16'h0000);
    chk32({31'h0, last_err}, 32'h1);
    rdc(A_EN, 16'hFFF1, 16'h0000);
    test_done();
  end
endmodule
